// file: logic/irt_defines.vh
// Constants of the infrared remote transmitter: scan, word and pulse timing.
// Assumes one clock of 200 MHz; one clock cycle stands for one oscillator
// period in all pulse-distance figures.
`ifndef IRT_DEFINES_VH
`define IRT_DEFINES_VH

// ----------------------------------------------------------------------
// Clock and lock-up limit
// ----------------------------------------------------------------------
// One cycle short of 1 ms at 200 MHz
`define IRT_MAX_HIGH_CYC 18'h30d3f

// ----------------------------------------------------------------------
// Word format
// ----------------------------------------------------------------------
`define IRT_WORD_BITS 11
`define IRT_LAST_PULSE 4'hb
`define IRT_REF_BIT 1'b0
`define IRT_GND_ROW 3'h7
`define IRT_COMBO_ROW 3'h7
`define IRT_LAST_DRV 3'h6

// ----------------------------------------------------------------------
// Pulse-distance timing, in oscillator periods or units
// ----------------------------------------------------------------------
`define IRT_UNIT_FLASH 11'h480
`define IRT_UNIT_MOD 11'h600
`define IRT_WORD_UNITS 6'h30
`define IRT_ZERO_UNITS 6'h02
`define IRT_ONE_UNITS 6'h03
`define IRT_FLASH_HIGH 11'h004
`define IRT_MOD_BURST_CYC 11'h060
`define IRT_MOD_PERIOD 4'hc
`define IRT_MOD_HIGH 4'h6

// ----------------------------------------------------------------------
// Scan timing, in clock cycles
// ----------------------------------------------------------------------
`define IRT_DEBOUNCE_CYC 16'h0800
`define IRT_SETTLE_CYC 16'h0006
`define IRT_SCAN_GAP_CYC 16'h0400
`define IRT_FAST_GAP_CYC 16'h0040
`define IRT_KEY_UP_HOLD_CYC 16'h0fa0

`endif

// file: logic/irt_word_buf.v
// Two-entry word buffer between the key scanner and the pulse serialiser.
// Assumes both sides on one clock; reset is the synchronised copy.
`timescale 1ns/1ps
module irt_word_buf (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [11:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [11:0] out_data
);
  reg [11:0] mem_q [0:1];
  reg wp_q;
  reg rp_q;
  reg [1:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data = mem_q[rp_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_q[0] <= 12'h000;
      mem_q[1] <= 12'h000;
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 2'h1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule

// file: logic/irt_tx_encoder.v
// Infrared remote transmitter: key matrix scanner, group/mode decoder and
// pulse-distance serialiser with lock-up guard.
// Assumes the matrix and mode strap are asynchronous pins; the clock
// stands in for the resonator oscillator.
//
// Notes on behaviour
// - Seven open-drain drive outputs, all conducting low in stand-by.
// - Seven sense lines give 56 codes, 64 with two diodes.
// - Sense lines idle high; a low sense line starts transmission.
// - Mode input pulled down in stand-by, pulled up once active.
// - No drive line on mode input: group 0, flashed.
// - Highest drive line on mode input selects modulated output.
// - Highest-numbered connected drive line 0-5 sets the group.
// - Drive line 1 gives group 2; adding line 3 gives 4.
// - Mode input changes alone never start a transmission.
// - Bits coded as distance between leading pulse edges.
// - Word: two toggle bits, group MSB first, key code MSB first.
// - Modulated mode replaces first toggle bit by constant reference.
// - Any high output pulse is cut off below 1 ms.
// - Key press wakes oscillator, debounces, then scans drive lines.
// - First scan senses mode, group and key into a latch.
// - Group sampled only in first scan, then held.
// - Key code follows the sensed key in multi-key sequences.
// - No new output starts while several keys are pressed.
// - Faster scan repetition while several keys are pressed.
// - A grounded sense line masks its other keys; sends ground code.
// - Sense five and six on one drive line form codes 56-63.
// - Toggle advances only after long release, not within sequences.
// - Unit is 1152 periods flashed, 1536 periods modulated.
// - Words repeat while a key stays pressed.
// - A started word is always finished after release.
`timescale 1ns/1ps
`include "irt_defines.vh"
module irt_tx_encoder #(
  parameter [17:0] MAX_HIGH_CYC = `IRT_MAX_HIGH_CYC
) (
  input wire clk,
  input wire resetn,
  input wire [6:0] key_sense_lines_n,
  input wire group_mode_select_in,
  output reg [6:0] key_drive_lines_o,
  output reg [6:0] key_drive_lines_oe,
  output reg mode_pullup_en,
  output reg mode_pulldown_en,
  output reg osc_enable,
  output reg ir_pulse_out
);
  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [2:0] SC_STBY = 3'h0;
  localparam [2:0] SC_DEB = 3'h1;
  localparam [2:0] SC_GND = 3'h2;
  localparam [2:0] SC_DRV = 3'h3;
  localparam [2:0] SC_EVAL = 3'h4;
  localparam [2:0] SC_PUSH = 3'h5;
  localparam [2:0] SC_GAP = 3'h6;
  localparam TX_IDLE = 1'b0;
  localparam TX_RUN = 1'b1;

  // --------------------------------------------------------------------
  // Decode helpers
  // --------------------------------------------------------------------
  function [2:0] pop7;
    input [6:0] v;
    integer i;
    begin
      pop7 = 3'h0;
      for (i = 0; i < 7; i = i + 1) begin
        pop7 = pop7 + {2'b00, v[i]};
      end
    end
  endfunction

  function [2:0] low_idx7;
    input [6:0] v;
    integer i;
    begin
      low_idx7 = 3'h0;
      for (i = 6; i >= 0; i = i - 1) begin
        if (v[i]) begin
          low_idx7 = i[2:0];
        end
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Reset release and input synchronisers
  // --------------------------------------------------------------------
  reg rst_s1_q;
  reg rst_s2_q;
  reg [6:0] sense_s1_q;
  reg [6:0] sense_s2_q;
  reg mode_s1_q;
  reg mode_s2_q;
  wire rst_n;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_n = rst_s2_q;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sense_s1_q <= 7'h7f;
      sense_s2_q <= 7'h7f;
      mode_s1_q <= 1'b0;
      mode_s2_q <= 1'b0;
    end else begin
      sense_s1_q <= key_sense_lines_n;
      sense_s2_q <= sense_s1_q;
      mode_s1_q <= group_mode_select_in;
      mode_s2_q <= mode_s1_q;
    end
  end

  // --------------------------------------------------------------------
  // Scanner state
  // --------------------------------------------------------------------
  reg [2:0] sc_q;
  reg [15:0] cnt_q;
  reg [2:0] drv_q;
  reg [6:0] gnd_q;
  reg [1:0] kcnt_q;
  reg [5:0] scode_q;
  reg [5:0] code_q;
  reg [2:0] grp_scan_q;
  reg mod_scan_q;
  reg [2:0] grp_q;
  reg mod_q;
  reg first_q;
  reg [1:0] tog_q;
  reg [15:0] rel_q;
  reg had_key_q;
  reg multi_q;
  reg push_q;
  wire [6:0] pressed;
  wire [6:0] live;
  wire combo;
  wire [6:0] single;
  wire [2:0] nkeys;
  wire [5:0] step_code;
  wire [3:0] ksum;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [11:0] buf_out_data;
  wire buf_out_ready;
  wire tx_busy;
  wire [11:0] word_in;

  assign pressed = ~sense_s2_q;
  // grounded lines mask their other keys
  assign live = (sc_q == SC_GND) ? pressed : (pressed & ~gnd_q);
  // sense five and six together are one key
  assign combo = live[5] & live[6];
  assign single = combo ? (live & 7'h1f) : live;
  assign nkeys = pop7(single) + {2'b00, combo};
  // code is row times eight plus drive column
  assign step_code = (sc_q == SC_GND) ?
    (combo ? {`IRT_COMBO_ROW, `IRT_GND_ROW} :
             {low_idx7(single), `IRT_GND_ROW}) :
    (combo ? {`IRT_COMBO_ROW, drv_q} : {low_idx7(single), drv_q});
  assign ksum = {2'b00, kcnt_q} + {1'b0, nkeys};
  // toggle pair, group, key code; reference bit
  assign word_in = {mod_q, (mod_q ? `IRT_REF_BIT : tog_q[1]), tog_q[0],
                    grp_q, code_q};

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sc_q <= SC_STBY;
      cnt_q <= 16'h0000;
      drv_q <= 3'h0;
      gnd_q <= 7'h00;
      kcnt_q <= 2'h0;
      scode_q <= 6'h00;
      code_q <= 6'h00;
      grp_scan_q <= 3'h0;
      mod_scan_q <= 1'b0;
      grp_q <= 3'h0;
      mod_q <= 1'b0;
      first_q <= 1'b0;
      tog_q <= 2'h0;
      rel_q <= 16'h0000;
      had_key_q <= 1'b0;
      multi_q <= 1'b0;
      push_q <= 1'b0;
      key_drive_lines_o <= 7'h00;
      key_drive_lines_oe <= 7'h7f;
      mode_pullup_en <= 1'b0;
      mode_pulldown_en <= 1'b1;
      osc_enable <= 1'b0;
    end else begin
      key_drive_lines_o <= 7'h00;
      if (rel_q != 16'hffff) begin
        rel_q <= rel_q + 16'h0001;
      end
      case (sc_q)
        SC_STBY: begin
          key_drive_lines_oe <= 7'h7f;
          mode_pullup_en <= 1'b0;
          mode_pulldown_en <= 1'b1;
          osc_enable <= 1'b0;
          multi_q <= 1'b0;
          // only a sense line wakes the transmitter
          if (pressed != 7'h00) begin
            sc_q <= SC_DEB;
            cnt_q <= 16'h0000;
            osc_enable <= 1'b1;
            mode_pullup_en <= 1'b1;
            mode_pulldown_en <= 1'b0;
            first_q <= 1'b1;
            rel_q <= 16'h0000;
          end
        end
        SC_DEB: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `IRT_DEBOUNCE_CYC) begin
            sc_q <= SC_GND;
            cnt_q <= 16'h0000;
            key_drive_lines_oe <= 7'h00;
            kcnt_q <= 2'h0;
            grp_scan_q <= 3'h0;
            mod_scan_q <= 1'b0;
          end
        end
        SC_GND, SC_DRV: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == `IRT_SETTLE_CYC) begin
            cnt_q <= 16'h0000;
            kcnt_q <= (ksum > 4'h2) ? 2'h2 : ksum[1:0];
            if (nkeys != 3'h0) begin
              scode_q <= step_code;
            end
            if (sc_q == SC_GND) begin
              gnd_q <= pressed;
              sc_q <= SC_DRV;
              drv_q <= 3'h0;
              key_drive_lines_oe <= 7'h01;
            end else begin
              // later, higher drive lines overwrite the group
              if (!mode_s2_q) begin
                if (drv_q == `IRT_LAST_DRV) begin
                  mod_scan_q <= 1'b1;
                end else begin
                  // drive line n gives group n plus one
                  grp_scan_q <= drv_q + 3'h1;
                end
              end
              if (drv_q == `IRT_LAST_DRV) begin
                sc_q <= SC_EVAL;
                key_drive_lines_oe <= 7'h00;
              end else begin
                // drive lines active one after another
                drv_q <= drv_q + 3'h1;
                key_drive_lines_oe <= key_drive_lines_oe << 1;
              end
            end
          end
        end
        SC_EVAL: begin
          cnt_q <= 16'h0000;
          // group and mode latched in first scan only
          // nothing connected leaves group 0, flashed
          if (first_q) begin
            grp_q <= grp_scan_q;
            mod_q <= mod_scan_q;
            first_q <= 1'b0;
          end
          if (kcnt_q == 2'h1) begin
            // code follows the key now sensed
            code_q <= scode_q;
            had_key_q <= 1'b1;
            multi_q <= 1'b0;
            rel_q <= 16'h0000;
            sc_q <= SC_PUSH;
            push_q <= 1'b1;
          end else if (kcnt_q == 2'h0) begin
            multi_q <= 1'b0;
            sc_q <= SC_GAP;
            if (rel_q >= `IRT_KEY_UP_HOLD_CYC && !tx_busy &&
                !buf_out_valid) begin
              // toggle advances after long release only
              if (had_key_q) begin
                tog_q <= tog_q + 2'h1;
              end
              had_key_q <= 1'b0;
              sc_q <= SC_STBY;
            end
          end else begin
            // several keys: no word, rescan sooner
            multi_q <= 1'b1;
            rel_q <= 16'h0000;
            sc_q <= SC_GAP;
          end
        end
        SC_PUSH: begin
          // Scanner stalls here while the buffer is full
          if (buf_in_ready) begin
            push_q <= 1'b0;
            sc_q <= SC_GAP;
          end
        end
        SC_GAP: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == (multi_q ? `IRT_FAST_GAP_CYC : `IRT_SCAN_GAP_CYC))
          begin
            sc_q <= SC_GND;
            cnt_q <= 16'h0000;
            kcnt_q <= 2'h0;
          end
        end
        default: begin
          sc_q <= SC_STBY;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Word buffer
  // --------------------------------------------------------------------
  // each scan with one key queues another word
  irt_word_buf u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push_q),
    .in_ready(buf_in_ready),
    .in_data(word_in),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // --------------------------------------------------------------------
  // Serialiser
  // --------------------------------------------------------------------
  reg tx_q;
  reg [10:0] tx_word_q;
  reg tx_mod_q;
  reg [3:0] pidx_q;
  reg [10:0] ucnt_q;
  reg [5:0] units_q;
  reg [5:0] tgt_q;
  reg [5:0] total_q;
  reg [3:0] mph_q;
  reg [17:0] hi_cnt_q;
  wire [10:0] unit_len;
  wire unit_end;
  wire ival_end;
  wire word_end;
  wire pulse_on;
  wire [10:0] nxt_word;
  wire [5:0] nxt_tgt;

  assign unit_len = tx_mod_q ? `IRT_UNIT_MOD : `IRT_UNIT_FLASH;
  assign unit_end = (ucnt_q == unit_len - 11'h001);
  assign ival_end = unit_end && (units_q == tgt_q - 6'h01);
  // a word runs to its end regardless of the keys
  assign word_end = ival_end && (pidx_q == `IRT_LAST_PULSE);
  assign tx_busy = tx_q;
  // hold back a queued word during a multi-key press
  assign buf_out_ready = ~multi_q & (~tx_q | word_end);
  assign nxt_word = tx_word_q << 1;
  // zero is two units, one is three
  assign nxt_tgt = (pidx_q == `IRT_LAST_PULSE - 4'h1) ?
    (`IRT_WORD_UNITS - total_q - tgt_q) :
    (nxt_word[10] ? `IRT_ONE_UNITS : `IRT_ZERO_UNITS);
  // pulse sits at the start of each interval
  assign pulse_on = tx_q && (units_q == 6'h00) &&
    (tx_mod_q ? ((ucnt_q < `IRT_MOD_BURST_CYC) && (mph_q < `IRT_MOD_HIGH))
              : (ucnt_q < `IRT_FLASH_HIGH));

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= TX_IDLE;
      tx_word_q <= 11'h000;
      tx_mod_q <= 1'b0;
      pidx_q <= 4'h0;
      ucnt_q <= 11'h000;
      units_q <= 6'h00;
      tgt_q <= 6'h00;
      total_q <= 6'h00;
      mph_q <= 4'h0;
    end else if (buf_out_valid && buf_out_ready) begin
      tx_q <= TX_RUN;
      tx_word_q <= buf_out_data[10:0];
      tx_mod_q <= buf_out_data[11];
      pidx_q <= 4'h0;
      ucnt_q <= 11'h000;
      units_q <= 6'h00;
      tgt_q <= buf_out_data[10] ? `IRT_ONE_UNITS : `IRT_ZERO_UNITS;
      total_q <= 6'h00;
      mph_q <= 4'h0;
    end else if (word_end) begin
      tx_q <= TX_IDLE;
    end else if (tx_q == TX_RUN) begin
      mph_q <= (mph_q == `IRT_MOD_PERIOD - 4'h1) ? 4'h0 : mph_q + 4'h1;
      ucnt_q <= unit_end ? 11'h000 : ucnt_q + 11'h001;
      if (ival_end) begin
        tx_word_q <= nxt_word;
        pidx_q <= pidx_q + 4'h1;
        units_q <= 6'h00;
        total_q <= total_q + tgt_q;
        tgt_q <= nxt_tgt;
        mph_q <= 4'h0;
      end else if (unit_end) begin
        units_q <= units_q + 6'h01;
      end
    end
  end

  // --------------------------------------------------------------------
  // Output stage with lock-up guard
  // --------------------------------------------------------------------
  // Counter guard only; a stopped clock needs an analog timer as well
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ir_pulse_out <= 1'b0;
      hi_cnt_q <= 18'h00000;
    end else begin
      // high time capped below the limit
      if (pulse_on && hi_cnt_q < MAX_HIGH_CYC) begin
        ir_pulse_out <= 1'b1;
        hi_cnt_q <= hi_cnt_q + 18'h00001;
      end else begin
        ir_pulse_out <= 1'b0;
        if (!pulse_on) begin
          hi_cnt_q <= 18'h00000;
        end
      end
    end
  end
endmodule

// file: tb/irt_key_matrix.sv
// Key matrix and mode strap model for the transmitter pins.
// Assumes the bench sets pressed keys, ground keys and strap diodes.
`timescale 1ns/1ps
module irt_key_matrix (
  input wire clk,
  input wire [6:0] drive_oe,
  input wire pullup_en,
  input wire pulldown_en,
  input wire [48:0] keys,
  input wire [6:0] gnd_keys,
  input wire [6:0] strap,
  output logic [6:0] sense_n,
  output logic mode_in
);
  logic float_q = 1'b0;
  integer j;
  // Unloaded strap wanders so a missing load shows
  always @(posedge clk) float_q <= ~float_q;
  always @* begin
    for (j = 0; j < 7; j = j + 1) begin
      sense_n[j] = ~(gnd_keys[j] | (|(keys[j*7 +: 7] & drive_oe)));
    end
    if (|(strap & drive_oe))
      mode_in = 1'b0;
    else if (pullup_en)
      mode_in = 1'b1;
    else if (pulldown_en)
      mode_in = 1'b0;
    else
      mode_in = float_q;
  end
endmodule

// file: tb/irt_tx_checker.sv
// Port-level checks of the infrared transmitter.
// Assumes it is bound into irt_tx_encoder and sees only its ports.
`timescale 1ns/1ps
module irt_tx_checker #(
  parameter [17:0] MAX_HIGH_CYC = 18'h30d3f
) (
  input wire clk,
  input wire resetn,
  input wire [6:0] key_sense_lines_n,
  input wire group_mode_select_in,
  input wire [6:0] key_drive_lines_o,
  input wire [6:0] key_drive_lines_oe,
  input wire mode_pullup_en,
  input wire mode_pulldown_en,
  input wire osc_enable,
  input wire ir_pulse_out
);
  logic [17:0] high_cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  always @(posedge clk or negedge resetn) begin
    if (!resetn)
      high_cnt_q <= 18'h00000;
    else if (ir_pulse_out)
      high_cnt_q <= high_cnt_q + 18'h00001;
    else
      high_cnt_q <= 18'h00000;
  end
  sequence s_hold_step;
    $stable(key_drive_lines_oe)[*6];
  endsequence
  // Flash pulse is 4 high, carrier pulse 6 high
  sequence s_pulse_body;
    ir_pulse_out[*4] ##1 ((!ir_pulse_out) or
      (ir_pulse_out[*2] ##1 !ir_pulse_out));
  endsequence
  AST_STANDBY_DRIVE: assert property (
    !osc_enable && $past(!osc_enable) |->
      key_drive_lines_oe == 7'h7f && key_drive_lines_o == 7'h00)
    else $error("drive lines not all on in stand-by");
  AST_LOADS_EXCL: assert property (
    mode_pullup_en != mode_pulldown_en)
    else $error("strap loads not exclusive");
  AST_LOADS_WAKE: assert property (
    $rose(osc_enable) |-> mode_pullup_en && !mode_pulldown_en)
    else $error("strap loads not switched on wake");
  AST_SCAN_ONEHOT: assert property (
    $onehot0(key_drive_lines_oe) || key_drive_lines_oe == 7'h7f)
    else $error("more than one drive line scanned");
  AST_SCAN_STEP: assert property (
    $changed(key_drive_lines_oe) && $onehot(key_drive_lines_oe) &&
      !key_drive_lines_oe[6] |=> s_hold_step ##1
      (key_drive_lines_oe == ($past(key_drive_lines_oe, 7) << 1)))
    else $error("scan step length or order wrong");
  AST_NO_STRAP_WAKE: assert property (
    (!osc_enable && (&key_sense_lines_n))[*5] |=> !osc_enable)
    else $error("woke without key");
  AST_KEY_WAKE: assert property (
    (!osc_enable && !(&key_sense_lines_n))[*4] |-> ##[0:3] osc_enable)
    else $error("key press did not wake");
  AST_IR_AWAKE: assert property (
    ir_pulse_out |-> osc_enable)
    else $error("pulse while asleep");
  AST_HIGH_CAP: assert property (
    ir_pulse_out |-> high_cnt_q < MAX_HIGH_CYC)
    else $error("output pulse too long");
  AST_PULSE_SHAPE: assert property (
    $rose(ir_pulse_out) |-> s_pulse_body)
    else $error("pulse width wrong");
endmodule

bind irt_tx_encoder irt_tx_checker #(.MAX_HIGH_CYC(MAX_HIGH_CYC)) chk_u (
  .clk(clk),
  .resetn(resetn),
  .key_sense_lines_n(key_sense_lines_n),
  .group_mode_select_in(group_mode_select_in),
  .key_drive_lines_o(key_drive_lines_o),
  .key_drive_lines_oe(key_drive_lines_oe),
  .mode_pullup_en(mode_pullup_en),
  .mode_pulldown_en(mode_pulldown_en),
  .osc_enable(osc_enable),
  .ir_pulse_out(ir_pulse_out)
);

// file: tb/tb.sv
// Self-checking bench of the transmitter with a key matrix model.
// Assumes irt_defines.vh on the include path; one 200 MHz clock.
`timescale 1ns/1ps
`include "irt_defines.vh"
module tb;
  logic clk;
  logic resetn;
  logic [48:0] keys;
  logic [6:0] gnd_keys;
  logic [6:0] strap;
  wire [6:0] sense_n;
  wire [6:0] drv_o;
  wire [6:0] drv_oe;
  wire mode_in;
  wire pu;
  wire pd;
  wire osc;
  wire ir;
  integer n_mismatch = 0;
  integer checked = 0;
  integer cyc = 0;
  // Small cap of 50 cycles, still above the 6-cycle carrier pulse
  irt_tx_encoder #(.MAX_HIGH_CYC(18'h32)) dut_u (
    .clk(clk),
    .resetn(resetn),
    .key_sense_lines_n(sense_n),
    .group_mode_select_in(mode_in),
    .key_drive_lines_o(drv_o),
    .key_drive_lines_oe(drv_oe),
    .mode_pullup_en(pu),
    .mode_pulldown_en(pd),
    .osc_enable(osc),
    .ir_pulse_out(ir)
  );
  irt_key_matrix matrix_u (
    .clk(clk),
    .drive_oe(drv_oe),
    .pullup_en(pu),
    .pulldown_en(pd),
    .keys(keys),
    .gnd_keys(gnd_keys),
    .strap(strap),
    .sense_n(sense_n),
    .mode_in(mode_in)
  );
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_mismatch = n_mismatch + 1;
      test_done;
    end
  end
  task test_done;
    begin
      if (n_mismatch == 0 && checked > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task do_reset;
    begin
      @(posedge clk);
      resetn <= 1'b0;
      keys <= 49'h0;
      gnd_keys <= 7'h00;
      strap <= 7'h00;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
    end
  endtask
  // Leading edges within 200 cycles belong to one carrier burst
  task get_word(input integer n, input integer unit, input logic rel,
                output logic [10:0] w);
    integer t;
    integer t0;
    integer i;
    integer d;
    logic prev;
    logic cut;
    begin
      w = 11'h000;
      t = 0;
      t0 = -1;
      i = 0;
      prev = 1'b0;
      cut = 1'b0;
      while (i < n && t < 70000) begin
        @(posedge clk);
        // Release means ground keys too
        if (cut) begin
          keys <= 49'h0;
          gnd_keys <= 7'h00;
        end
        #1;
        t = t + 1;
        if (ir === 1'b1 && !prev && (t0 < 0 || t - t0 > 200)) begin
          if (t0 >= 0) begin
            d = t - t0;
            cmp("pulse distance", 1, d == 2*unit || d == 3*unit);
            w = {w[9:0], d == 3*unit};
            i = i + 1;
          end
          t0 = t;
          cut = rel;
        end
        prev = (ir === 1'b1);
      end
      cmp("word edge count", n, i);
    end
  endtask
  task t_standby;
    begin
      do_reset;
      cmp("stand-by drive enables", 7'h7f, drv_oe);
      cmp("stand-by pull-down", 1'b1, pd);
      cmp("stand-by pull-up", 1'b0, pu);
      @(posedge clk);
      strap <= 7'h7f;
      repeat (40) @(posedge clk);
      #1;
      cmp("wake on strap change", 1'b0, osc);
    end
  endtask
  task t_flash_ground;
    logic [10:0] w;
    begin
      do_reset;
      @(posedge clk);
      gnd_keys <= 7'h01;
      keys <= 49'h4;
      repeat (10) @(posedge clk);
      #1;
      cmp("active pull-up", 1'b1, pu);
      cmp("oscillator on", 1'b1, osc);
      get_word(11, `IRT_UNIT_FLASH, 1'b1, w);
      cmp("group and key code", 9'h007, w[8:0]);
    end
  endtask
  task t_group;
    logic [6:0] straps [0:1];
    logic [2:0] grp [0:1];
    logic [10:0] w;
    integer i;
    begin
      straps[0] = 7'h02;
      grp[0] = 3'h2;
      straps[1] = 7'h4a;
      grp[1] = 3'h4;
      for (i = 0; i < 2; i = i + 1) begin
        do_reset;
        @(posedge clk);
        strap <= straps[i];
        // Sense five and six on drive 0 form one key
        keys <= (i == 0) ? 49'h040800000000 : 49'h4000;
        if (i == 0) begin
          get_word(8, `IRT_UNIT_FLASH, 1'b0, w);
          cmp("combined key row", 3'h7, w[2:0]);
          w = w >> 3;
        end else begin
          get_word(5, `IRT_UNIT_MOD, 1'b0, w);
          cmp("reference bit", `IRT_REF_BIT, w[4]);
        end
        cmp("group bits", grp[i], w[2:0]);
      end
    end
  endtask
  task t_multi;
    integer k;
    integer t1;
    integer t2;
    logic seen;
    logic prev01;
    begin
      do_reset;
      @(posedge clk);
      keys <= 49'h101;
      t1 = 0;
      t2 = 0;
      seen = 1'b0;
      prev01 = 1'b0;
      for (k = 1; k < 6000; k = k + 1) begin
        @(posedge clk);
        #1;
        if (ir !== 1'b0)
          seen = 1'b1;
        if (drv_oe === 7'h01 && !prev01) begin
          t1 = t2;
          t2 = k;
        end
        prev01 = (drv_oe === 7'h01);
      end
      cmp("pulse during multi key", 1'b0, seen);
      cmp("fast rescan", 1'b1, t1 > 0 && t2 - t1 < 200);
    end
  endtask
  initial begin
    resetn = 1'b0;
    keys = 49'h0;
    gnd_keys = 7'h00;
    strap = 7'h00;
    t_standby;
    t_flash_ground;
    t_group;
    t_multi;
    test_done;
  end
endmodule
